// [shared/topdown_pkg.sv]
// constants for the top-down metrics and response qualifier block
// assumes a 32-bit avalon-mm register bus and one core clock
package topdown_pkg;
   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [5:0] OFS_QUAL_LO  = 6'h00;
   localparam logic [5:0] OFS_QUAL_HI  = 6'h04;
   localparam logic [5:0] OFS_GCTRL_HI = 6'h08;
   localparam logic [5:0] OFS_GSTAT_HI = 6'h0C;
   localparam logic [5:0] OFS_FORCE_HI = 6'h10;
   localparam logic [5:0] OFS_CLEAR_HI = 6'h14;
   localparam logic [5:0] OFS_METRICS  = 6'h18;
   localparam logic [5:0] OFS_SLOTS    = 6'h1C;
   localparam logic [5:0] OFS_CAPS     = 6'h20;
   // ----------------------------------------------------------------
   // field positions (upper words hold bits 63:32)
   // ----------------------------------------------------------------
   localparam int BIT_TOPDOWN_HI = 16;
   localparam int BIT_SLOTCTR_HI = 3;
   localparam int BIT_FEATURE    = 15;
   localparam int BIT_ANY_RESP   = 16;
   localparam int FRAC_W         = 8;
   localparam int NUM_FRAC       = 4;
   localparam logic [39:0] FRAC_FULL  = 40'h00_0000_00FF;
   localparam logic [39:0] SNOOP_MASK = 40'h17_0000_0000;
   localparam logic [39:0] L3HIT_MASK = 40'h00_001C_0000;
   localparam logic [39:0] DRAM_MASK  = 40'h01_8400_0000;
   localparam logic [39:0] NDRAM_MASK = 40'h20_0400_0000;
   localparam logic [39:0] MISS_MASK  = 40'h3F_FFC0_0000;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] RST_WORD  = 32'h0000_0000;
   localparam logic [7:0]  RST_QUALH = 8'h00;
endpackage

// [rtl/topdown_monitor.sv]
// top-down metrics, response qualifier and sample skid control
// assumes software on the core reaches it over avalon-mm, one clock
//
// Local design decisions: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
// What this block does
// - snoop bit 32 selects requests that needed no snoop
// - snoop bit 33 selects snoops that missed every cache
// - snoop bit 34 selects clean hits not returned, last level valid
// - snoop bit 36 selects dirty hits forwarded to the requester
// - combined categories count only with all their bits set
// - any-response bit 16 overrides response bits 17 to 39
// - metrics register holds four 8-bit fractions of 255, low word
// - capability bit 15 reports the metrics feature
// - metrics run only with bit 48 and slot counter enable set
// - writing one to force bit 48 sets the overflow flag
// - writing one to clear bit 48 clears the overflow flag
// - metrics overflow sets flag 48 and raises an interrupt
// - fractions derive from the slot counter, fixed counter 3
// - exit on a buffer access holds the record until resume
// - held record skids one event, or one instruction if imprecise
module topdown_monitor
   import topdown_pkg::*;
(
   input  logic        mclk,
   input  logic        resetn,
   input  logic [5:0]  address,
   input  logic        read,
   input  logic        write,
   input  logic [31:0] writedata,
   input  logic [3:0]  byteenable,
   output logic [31:0] readdata,
   output logic        waitrequest,
   input  logic        resp_valid,
   input  logic [39:0] resp_info,
   output logic        resp_match,
   input  logic        slot_valid,
   input  logic [1:0]  slot_category,
   output logic        counter_overflow_interrupt,
   input  logic        sample_pending,
   input  logic        buffer_exit,
   input  logic        guest_resumed,
   input  logic        precise_event,
   input  logic        event_occurred,
   input  logic        instr_retired,
   output logic        record_write
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SK_IDLE = 3'b001,
      SK_HELD = 3'b010,
      SK_SKID = 3'b100
   } skid_t;

   logic        wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   logic [31:0] qual_lo_q, qual_lo_d;
   logic [7:0]  qual_hi_q, qual_hi_d;
   logic [31:0] gctrl_q, gctrl_d;
   logic [31:0] gstat_q, gstat_d;
   logic [31:0] metrics_q, metrics_d;
   logic [31:0] slots_q, slots_d;
   logic [31:0] cat_q [NUM_FRAC];
   logic [31:0] cat_d [NUM_FRAC];
   logic        match_q, match_d;
   logic        irq_q, irq_d;
   logic        rec_q, rec_d;
   skid_t       sk_q, sk_d;

   logic [31:0] bmask;
   logic        wr_go;
   logic        active;
   logic [39:0] cfg;
   logic        any_hit, comb_hit, supp_hit, snoop_hit;
   logic        cat_ovf, slot_ovf;
   logic [31:0] frac;

   assign readdata                   = rdata_q;
   assign waitrequest                = wait_q;
   assign resp_match                 = match_q;
   assign counter_overflow_interrupt = irq_q;
   assign record_write               = rec_q;

   assign bmask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                   {8{byteenable[1]}}, {8{byteenable[0]}}};
   assign wr_go = write && !wait_q;
   assign cfg   = {qual_hi_q, qual_lo_q};
   assign active = gctrl_q[BIT_TOPDOWN_HI]
                   && gctrl_q[BIT_SLOTCTR_HI];

   // ----------------------------------------------------------------
   // response qualifier
   // ----------------------------------------------------------------
   always_comb begin
      any_hit  = cfg[BIT_ANY_RESP];
      comb_hit = (((cfg & DRAM_MASK) == DRAM_MASK)
                  && ((resp_info & DRAM_MASK) != 40'h00_0000_0000))
              || (((cfg & NDRAM_MASK) == NDRAM_MASK)
                  && ((resp_info & NDRAM_MASK) != 40'h00_0000_0000))
              || (((cfg & MISS_MASK) == MISS_MASK)
                  && ((resp_info & MISS_MASK) != 40'h00_0000_0000));
      supp_hit = ((cfg & L3HIT_MASK) == L3HIT_MASK)
              && ((resp_info & L3HIT_MASK) != 40'h00_0000_0000);
      // positions 30 and 35 are outside the snoop mask
      snoop_hit = (cfg & resp_info & SNOOP_MASK)
                  != 40'h00_0000_0000;
      match_d  = resp_valid && (any_hit || comb_hit
                                || (supp_hit && snoop_hit));
   end

   // ----------------------------------------------------------------
   // slot counter and metric fractions
   // ----------------------------------------------------------------
   always_comb begin
      slots_d  = slots_q;
      slot_ovf = 1'b0;
      cat_ovf  = 1'b0;
      for (int i = 0; i < NUM_FRAC; i++) begin
         cat_d[i] = cat_q[i];
      end
      if (gctrl_q[BIT_SLOTCTR_HI] && slot_valid) begin
         slots_d  = slots_q + 32'h0000_0001;
         slot_ovf = (slots_q == 32'hFFFF_FFFF);
      end
      if (active && slot_valid) begin
         for (int i = 0; i < NUM_FRAC; i++) begin
            if (slot_category == 2'(i)) begin
               cat_d[i] = cat_q[i] + 32'h0000_0001;
               cat_ovf  = (cat_q[i] == 32'hFFFF_FFFF);
            end
         end
      end
      if (wr_go && address == OFS_SLOTS) begin
         slots_d = (slots_q & ~bmask) | (writedata & bmask);
      end
      if (wr_go && address == OFS_METRICS) begin
         for (int i = 0; i < NUM_FRAC; i++) begin
            cat_d[i] = RST_WORD;
         end
      end
   end

   always_comb begin
      logic [39:0] num;
      num = 40'h00_0000_0000;
      for (int i = 0; i < NUM_FRAC; i++) begin
         num = {8'h00, cat_q[i]} * FRAC_FULL;
         if (slots_q == RST_WORD) begin
            frac[i*FRAC_W +: FRAC_W] = 8'h00;
         end else begin
            frac[i*FRAC_W +: FRAC_W] =
               8'(num / {8'h00, slots_q});
         end
      end
   end

   // ----------------------------------------------------------------
   // control, status and metrics registers
   // ----------------------------------------------------------------
   always_comb begin
      qual_lo_d = qual_lo_q;
      qual_hi_d = qual_hi_q;
      gctrl_d   = gctrl_q;
      gstat_d   = gstat_q;
      metrics_d = active ? frac : metrics_q;
      irq_d     = cat_ovf || slot_ovf;
      if (wr_go) begin
         unique case (address)
            OFS_QUAL_LO:  qual_lo_d = (qual_lo_q & ~bmask)
                                    | (writedata & bmask);
            OFS_QUAL_HI:  if (byteenable[0]) qual_hi_d = writedata[7:0];
            OFS_GCTRL_HI: gctrl_d = (gctrl_q & ~bmask)
                                  | (writedata & bmask);
            OFS_FORCE_HI: gstat_d = gstat_q | (writedata & bmask);
            OFS_CLEAR_HI: gstat_d = gstat_q & ~(writedata & bmask);
            OFS_METRICS:  metrics_d = (metrics_q & ~bmask)
                                    | (writedata & bmask);
            default: ;
         endcase
      end
      // hardware set wins over a same-cycle clear
      if (cat_ovf) begin
         gstat_d[BIT_TOPDOWN_HI] = 1'b1;
      end
      if (slot_ovf) begin
         gstat_d[BIT_SLOTCTR_HI] = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   always_comb begin
      wait_d  = !((read || write) && wait_q);
      rdata_d = rdata_q;
      if (read && wait_q) begin
         unique case (address)
            OFS_QUAL_LO:  rdata_d = qual_lo_q;
            OFS_QUAL_HI:  rdata_d = {24'h00_0000, qual_hi_q};
            OFS_GCTRL_HI: rdata_d = gctrl_q;
            OFS_GSTAT_HI: rdata_d = gstat_q;
            OFS_METRICS:  rdata_d = metrics_q;
            OFS_SLOTS:    rdata_d = slots_q;
            OFS_CAPS:     rdata_d = 32'h0000_0001 << BIT_FEATURE;
            default:      rdata_d = RST_WORD;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // sample record skid
   // ----------------------------------------------------------------
   always_comb begin
      sk_d  = sk_q;
      rec_d = 1'b0;
      unique case (sk_q)
         SK_IDLE: if (sample_pending) begin
            if (buffer_exit) sk_d = SK_HELD;
            else rec_d = 1'b1;
         end
         SK_HELD: if (guest_resumed) sk_d = SK_SKID;
         SK_SKID: if (precise_event ? event_occurred : instr_retired) begin
            rec_d = 1'b1;
            sk_d  = SK_IDLE;
         end
         default: sk_d = SK_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wait_q    <= 1'b1;
         rdata_q   <= RST_WORD;
         qual_lo_q <= RST_WORD;
         qual_hi_q <= RST_QUALH;
         gctrl_q   <= RST_WORD;
         gstat_q   <= RST_WORD;
         metrics_q <= RST_WORD;
         slots_q   <= RST_WORD;
         for (int i = 0; i < NUM_FRAC; i++) cat_q[i] <= RST_WORD;
         match_q   <= 1'b0;
         irq_q     <= 1'b0;
         rec_q     <= 1'b0;
         sk_q      <= SK_IDLE;
      end else begin
         wait_q    <= wait_d;
         rdata_q   <= rdata_d;
         qual_lo_q <= qual_lo_d;
         qual_hi_q <= qual_hi_d;
         gctrl_q   <= gctrl_d;
         gstat_q   <= gstat_d;
         metrics_q <= metrics_d;
         slots_q   <= slots_d;
         for (int i = 0; i < NUM_FRAC; i++) cat_q[i] <= cat_d[i];
         match_q   <= match_d;
         irq_q     <= irq_d;
         rec_q     <= rec_d;
         sk_q      <= sk_d;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_wait_one_cycle: assert property (@(posedge mclk) disable iff (!resetn)
      (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
      else $error("waitrequest not low for exactly one cycle");
   a_any_overrides: assert property (@(posedge mclk)
      disable iff (!resetn)
      resp_valid && cfg[BIT_ANY_RESP] |=> resp_match)
      else $error("any-response bit did not match");
   a_reserved_ignored: assert property (@(posedge mclk)
      disable iff (!resetn)
      resp_valid && ((cfg & ~40'h08_4000_0000) == 40'h00_0000_0000)
      |=> !resp_match)
      else $error("reserved snoop bits produced a match");
   a_force_sets: assert property (@(posedge mclk)
      disable iff (!resetn)
      wr_go && address == OFS_FORCE_HI && byteenable[2]
      && writedata[BIT_TOPDOWN_HI] |=> gstat_q[BIT_TOPDOWN_HI])
      else $error("force write did not set overflow flag");
   a_clear_clears: assert property (@(posedge mclk)
      disable iff (!resetn)
      wr_go && address == OFS_CLEAR_HI && byteenable[2]
      && writedata[BIT_TOPDOWN_HI] && !cat_ovf
      |=> !gstat_q[BIT_TOPDOWN_HI])
      else $error("clear write did not clear overflow flag");
   a_ovf_irq: assert property (@(posedge mclk) disable iff (!resetn)
      cat_ovf |=> counter_overflow_interrupt && gstat_q[BIT_TOPDOWN_HI])
      else $error("metrics overflow without flag and interrupt");
   a_slot_ovf_irq: assert property (@(posedge mclk)
      disable iff (!resetn)
      slot_ovf |=> counter_overflow_interrupt && gstat_q[BIT_SLOTCTR_HI])
      else $error("slot counter overflow without flag and interrupt");
   a_metrics_frozen: assert property (@(posedge mclk)
      disable iff (!resetn)
      !active && !(wr_go && address == OFS_METRICS) |=> $stable(metrics_q))
      else $error("metrics moved while disabled");
   a_skid_held: assert property (@(posedge mclk)
      disable iff (!resetn)
      sk_q == SK_IDLE && sample_pending && buffer_exit
      ##1 !guest_resumed [*2] |-> !record_write)
      else $error("held record written before resume");
   a_caps_bit: assert property (@(posedge mclk) disable iff (!resetn)
      read && waitrequest && address == OFS_CAPS
      |=> readdata[BIT_FEATURE] && !waitrequest)
      else $error("capability feature bit missing");
endmodule // topdown_monitor

// [testbench/tb_top.sv]
// self-checking bench for the top-down metrics and qualifier block
// assumes the design package is compiled first; one 25 MHz clock
`timescale 1ns/1ps
module tb_top
   import topdown_pkg::*;
;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic        mclk = 1'b0;
   logic        resetn = 1'b0;
   logic [5:0]  address = 6'h00;
   logic        read = 1'b0;
   logic        write = 1'b0;
   logic [31:0] writedata = 32'h0000_0000;
   logic [3:0]  byteenable = 4'hF;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        resp_valid = 1'b0;
   logic [39:0] resp_info = 40'h00_0000_0000;
   logic        resp_match;
   logic        slot_valid = 1'b0;
   logic [1:0]  slot_category = 2'h0;
   logic        counter_overflow_interrupt;
   logic        sample_pending = 1'b0;
   logic        buffer_exit = 1'b0;
   logic        guest_resumed = 1'b0;
   logic        precise_event = 1'b0;
   logic        event_occurred = 1'b0;
   logic        instr_retired = 1'b0;
   logic        record_write;
   int          n_mismatch = 0;
   int          check_count = 0;
   int          rec_cnt = 0;
   int          irq_cnt = 0;
   logic [31:0] q;
   always #20 mclk = ~mclk;
   always @(posedge mclk) if (record_write === 1'b1) rec_cnt++;
   always @(posedge mclk) if (counter_overflow_interrupt === 1'b1) irq_cnt++;
   topdown_monitor DUT (.mclk(mclk), .resetn(resetn), .address(address),
      .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .resp_valid(resp_valid),
      .resp_info(resp_info), .resp_match(resp_match),
      .slot_valid(slot_valid), .slot_category(slot_category),
      .counter_overflow_interrupt(counter_overflow_interrupt),
      .sample_pending(sample_pending), .buffer_exit(buffer_exit),
      .guest_resumed(guest_resumed), .precise_event(precise_event),
      .event_occurred(event_occurred), .instr_retired(instr_retired),
      .record_write(record_write));
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [5:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge mclk);
      address   <= a;
      writedata <= d;
      write     <= wr;
      read      <= ~wr;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (n >= 50) chk(40'h1, 40'h0);
      r = readdata;
      read  <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic pulse(input int sel);
      @(posedge mclk);
      case (sel)
         0: sample_pending <= 1'b1;
         1: guest_resumed  <= 1'b1;
         2: event_occurred <= 1'b1;
         default: instr_retired <= 1'b1;
      endcase
      @(posedge mclk);
      sample_pending <= 1'b0;
      guest_resumed  <= 1'b0;
      event_occurred <= 1'b0;
      instr_retired  <= 1'b0;
   endtask
   task automatic rsp(input logic [39:0] info, input logic exp);
      @(posedge mclk);
      resp_valid <= 1'b1;
      resp_info  <= info;
      @(posedge mclk);
      resp_valid <= 1'b0;
      #1 chk({39'h0, resp_match}, {39'h0, exp});
   endtask
   task automatic cfg(input logic [39:0] c);
      bus(1'b1, OFS_QUAL_LO, c[31:0], q);
      bus(1'b1, OFS_QUAL_HI, {24'h0, c[39:32]}, q);
   endtask
   task automatic slot(input logic [1:0] c);
      @(posedge mclk);
      slot_valid    <= 1'b1;
      slot_category <= c;
      @(posedge mclk) slot_valid <= 1'b0;
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic test_done;
      $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs;
      bus(1'b0, OFS_CAPS, 32'h0, q);
      chk(q[BIT_FEATURE], 1'b1);
      bus(1'b0, 6'h3C, 32'h0, q);
      chk(q, 32'h0);
      $display("test regs done");
   endtask
   task automatic t_qual;
      logic [39:0] l3;
      int sn[4] = '{32, 33, 34, 36};
      l3 = 40'h00_0004_0000;
      foreach (sn[i]) begin
         cfg(L3HIT_MASK | (40'h1 << sn[i]));
         rsp(l3 | (40'h1 << sn[i]), 1'b1);
         rsp(l3 | (40'h1 << sn[(i + 1) % 4]), 1'b0);
      end
      cfg(L3HIT_MASK | 40'h08_4000_0000);
      rsp(l3 | 40'h08_0000_0000, 1'b0);
      rsp(l3 | 40'h00_4000_0000, 1'b0);
      cfg(40'h08_4000_0000);
      rsp(40'hFF_FFFF_FFFF, 1'b0);
      cfg(NDRAM_MASK);
      rsp(40'h00_0400_0000, 1'b1);
      cfg(40'h00_0400_0000);
      rsp(40'h00_0400_0000, 1'b0);
      cfg(40'h02_0001_0000 | L3HIT_MASK);
      rsp(40'h01_0000_0000, 1'b1);
      $display("test qual done");
   endtask
   task automatic t_metrics;
      bus(1'b1, OFS_GCTRL_HI, 32'h0001_0008, q);
      slot(2'd0);
      slot(2'd0);
      slot(2'd1);
      slot(2'd3);
      wait_n(3);
      bus(1'b0, OFS_METRICS, 32'h0, q);
      chk(q, 32'h3F00_3F7F);
      bus(1'b1, OFS_GCTRL_HI, 32'h0000_0008, q);
      slot(2'd0);
      slot(2'd0);
      wait_n(3);
      bus(1'b0, OFS_SLOTS, 32'h0, q);
      chk(q, 32'h6);
      bus(1'b0, OFS_METRICS, 32'h0, q);
      chk(q, 32'h3F00_3F7F);
      bus(1'b1, OFS_GCTRL_HI, 32'h0001_0000, q);
      slot(2'd1);
      wait_n(3);
      bus(1'b0, OFS_METRICS, 32'h0, q);
      chk(q, 32'h3F00_3F7F);
      $display("test metrics done");
   endtask
   task automatic t_ovf;
      chk(irq_cnt, 0);
      bus(1'b1, OFS_GCTRL_HI, 32'h0000_0008, q);
      bus(1'b1, OFS_SLOTS, 32'hFFFF_FFFF, q);
      slot(2'd0);
      wait_n(3);
      chk(irq_cnt, 1);
      bus(1'b0, OFS_GSTAT_HI, 32'h0, q);
      chk(q[BIT_SLOTCTR_HI], 1'b1);
      chk(q[BIT_TOPDOWN_HI], 1'b0);
      bus(1'b1, OFS_GCTRL_HI, 32'h0, q);
      bus(1'b1, OFS_SLOTS, 32'h0, q);
      bus(1'b1, OFS_METRICS, 32'h0, q);
      bus(1'b1, OFS_CLEAR_HI, 32'h0000_0008, q);
      bus(1'b0, OFS_METRICS, 32'h0, q);
      chk(q, 32'h0);
      bus(1'b1, OFS_GCTRL_HI, 32'h0001_0008, q);
      slot(2'd2);
      wait_n(3);
      bus(1'b0, OFS_METRICS, 32'h0, q);
      chk(q, 32'h00FF_0000);
      bus(1'b1, OFS_GCTRL_HI, 32'h0, q);
      $display("test overflow and restore done");
   endtask
   task automatic t_status;
      bus(1'b0, OFS_GSTAT_HI, 32'h0, q);
      chk(q[BIT_TOPDOWN_HI], 1'b0);
      bus(1'b1, OFS_FORCE_HI, 32'h0001_0000, q);
      bus(1'b0, OFS_GSTAT_HI, 32'h0, q);
      chk(q[BIT_TOPDOWN_HI], 1'b1);
      bus(1'b1, OFS_CLEAR_HI, 32'h0001_0000, q);
      bus(1'b0, OFS_GSTAT_HI, 32'h0, q);
      chk(q[BIT_TOPDOWN_HI], 1'b0);
      $display("test status done");
   endtask
   task automatic t_skid(input logic prec);
      int base;
      base = rec_cnt;
      precise_event <= prec;
      buffer_exit <= 1'b1;
      pulse(0);
      buffer_exit <= 1'b0;
      wait_n(4);
      chk(rec_cnt - base, 0);
      pulse(1);
      wait_n(3);
      if (prec) pulse(3);
      else pulse(2);
      wait_n(3);
      chk(rec_cnt - base, 0);
      if (prec) pulse(2);
      else pulse(3);
      wait_n(3);
      chk(rec_cnt - base, 1);
      $display("test skid done");
   endtask
   task automatic t_direct;
      int base;
      base = rec_cnt;
      pulse(0);
      wait_n(3);
      chk(rec_cnt - base, 1);
      $display("test direct record done");
   endtask
   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      t_regs();
      t_qual();
      t_metrics();
      t_status();
      t_ovf();
      t_direct();
      t_skid(1'b0);
      t_skid(1'b1);
      test_done();
   end
   initial begin
      #(40 * 5000);
      n_mismatch++;
      test_done();
   end
endmodule // tb_top
